// file: core/plldet_pkg.sv
// Purpose: shared constants for the phase detector and output divider
// Assumes: one clock domain, all pins synchronous to mclk
// Notes: detector states and divider and detector reset values live here
`default_nettype none
package plldet_pkg;
  // ---------------------------------------------------------------
  // detector states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PD_IDLE = 2'b00, // output floats, no edge pending
    PD_UP   = 2'b01, // reference led, output driven high
    PD_DOWN = 2'b10  // feedback led, output driven low
  } plldet_state_type;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_HALF = 1'h0; // halving flop starts low
  localparam logic RST_EDGE = 1'h0; // edge history starts low
  localparam logic RST_OSC_OUT = 1'h0; // oscillator output starts low
  localparam logic RST_DRIVE = 1'h0; // detector drive level starts low
  localparam logic RST_OE_N = 1'h1; // detector pad starts floating
endpackage : plldet_pkg
`default_nettype wire

// file: core/plldet_core.sv
// Purpose: edge phase frequency detector and selectable oscillator halving stage
// Assumes: osc_in, ref_in, fb_in are sampled levels synchronous to mclk
// Notes: the analog oscillator is outside; osc_in is its digital image
`default_nettype none
// Notes on behaviour
// - select high halves output, low passes through
// - osc disable stops oscillator, powers down
// - disabled oscillator output held low
// - detector disable floats detector output
// - disabled detector ignores all input edges
// - detector power-down independent of oscillator
// - edge-based comparison drives charge-pump output
module plldet_core (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic rstn, // async reset, active low
  input wire logic osc_in, // oscillator core level
  input wire logic divide_select, // high selects half rate
  input wire logic osc_disable, // high stops oscillator
  input wire logic detector_disable, // high floats detector
  input wire logic ref_in, // reference frequency input
  input wire logic fb_in, // feedback counter input
  output logic oscillator_output, // divided or direct oscillator
  output logic detector_output_o, // detector drive level
  output logic detector_output_oe_n // low while detector drives
);
  // ---------------------------------------------------------------
  // oscillator path
  // ---------------------------------------------------------------
  logic osc_prev_r, osc_prev_nxt; // last oscillator level
  logic half_r, half_nxt; // halving toggle flop
  logic osc_out_r, osc_out_nxt; // registered output
  logic osc_rise; // rising oscillator edge

  // the analog core is outside, so a stop here means its image is ignored:
  // edge history and halving flop sit at reset values while disabled, so
  // a restart always begins from a known phase
  // next-state of oscillator path
  always_comb begin
    osc_rise = osc_in & ~osc_prev_r;
    osc_prev_nxt = osc_disable ? plldet_pkg::RST_EDGE : osc_in;
    half_nxt = half_r;
    if (osc_disable) begin
      half_nxt = plldet_pkg::RST_HALF;
    end else if (osc_rise) begin
      half_nxt = ~half_r;
    end
    if (osc_disable) begin
      osc_out_nxt = 1'h0;
    end else if (divide_select) begin
      osc_out_nxt = half_nxt;
    end else begin
      // still registered: one cycle late, but free of glitches
      osc_out_nxt = osc_in;
    end
  end

  // register oscillator path
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      osc_prev_r <= plldet_pkg::RST_EDGE;
      half_r <= plldet_pkg::RST_HALF;
      osc_out_r <= plldet_pkg::RST_OSC_OUT;
    end else begin
      osc_prev_r <= osc_prev_nxt;
      half_r <= half_nxt;
      osc_out_r <= osc_out_nxt;
    end
  end

  // flop output, so a change of select cannot make a runt pulse
  assign oscillator_output = osc_out_r;

  // ---------------------------------------------------------------
  // phase detector
  // ---------------------------------------------------------------
  plldet_pkg::plldet_state_type st_r, st_nxt; // detector state
  logic ref_prev_r, ref_prev_nxt; // last reference level
  logic fb_prev_r, fb_prev_nxt; // last feedback level
  logic ref_rise, fb_rise; // edge strobes
  logic drv_r, drv_nxt; // driven level
  logic oe_n_r, oe_n_nxt; // enable, low drives

  // edge history runs even while disabled, so a line already high at
  // release is not taken for a fresh edge
  // next-state of detector; gated fully by disable, not by osc_disable
  always_comb begin
    ref_rise = ref_in & ~ref_prev_r;
    fb_rise = fb_in & ~fb_prev_r;
    ref_prev_nxt = ref_in;
    fb_prev_nxt = fb_in;
    st_nxt = st_r;
    if (detector_disable) begin
      st_nxt = plldet_pkg::PD_IDLE;
    end else begin
      case (st_r)
        plldet_pkg::PD_IDLE: begin
          // simultaneous edges cancel: no drive
          if (ref_rise && !fb_rise) begin
            st_nxt = plldet_pkg::PD_UP;
          end else if (fb_rise && !ref_rise) begin
            st_nxt = plldet_pkg::PD_DOWN;
          end
        end
        plldet_pkg::PD_UP: begin
          // a second reference edge is ignored here
          if (fb_rise) begin
            st_nxt = plldet_pkg::PD_IDLE;
          end
        end
        plldet_pkg::PD_DOWN: begin
          // a second feedback edge is ignored here
          if (ref_rise) begin
            st_nxt = plldet_pkg::PD_IDLE;
          end
        end
        default: begin
          // unused code: fall back to floating
          st_nxt = plldet_pkg::PD_IDLE;
        end
      endcase
    end
    drv_nxt = (st_nxt == plldet_pkg::PD_UP);
    oe_n_nxt = (st_nxt == plldet_pkg::PD_IDLE);
  end

  // register detector
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= plldet_pkg::PD_IDLE;
      ref_prev_r <= plldet_pkg::RST_EDGE;
      fb_prev_r <= plldet_pkg::RST_EDGE;
      // outputs come up quiet: no drive, pad floating
      drv_r <= plldet_pkg::RST_DRIVE;
      oe_n_r <= plldet_pkg::RST_OE_N;
    end else begin
      st_r <= st_nxt;
      ref_prev_r <= ref_prev_nxt;
      fb_prev_r <= fb_prev_nxt;
      drv_r <= drv_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // the pad turns oe_n high into high impedance
  assign detector_output_o = drv_r;
  assign detector_output_oe_n = oe_n_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // every output answers one edge after its inputs are sampled,
  // so each check looks one edge ahead of its cause
  // disabled oscillator shows a steady low
  AST_OSC_LOW: assert property (@(posedge mclk) disable iff (!rstn)
    osc_disable |=> !oscillator_output) else $error("output not low while disabled");
  // stopped oscillator leaves the halving flop cleared
  AST_OSC_STOP: assert property (@(posedge mclk) disable iff (!rstn)
    osc_disable |=> !half_r) else $error("halving flop ran while disabled");
  // select low passes the oscillator level through
  AST_PASS: assert property (@(posedge mclk) disable iff (!rstn)
    (!osc_disable && !divide_select) |=> oscillator_output == $past(osc_in))
    else $error("direct path wrong");
  // every clean rising oscillator edge flips the halving flop
  AST_HALF: assert property (@(posedge mclk) disable iff (!rstn)
    (!osc_disable && !$past(osc_disable) && osc_in && !$past(osc_in)) |=>
    half_r != $past(half_r)) else $error("halving missed edge");
  // halving flop holds between rising edges, keeping the duty balanced
  AST_HALF_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    (!osc_disable && !osc_rise) |=> half_r == $past(half_r))
    else $error("halving flop moved without edge");
  // select high shows the halving flop
  AST_DIV: assert property (@(posedge mclk) disable iff (!rstn)
    (!osc_disable && divide_select) |=> oscillator_output == half_r)
    else $error("halved path wrong");
  // a powered-down detector leaves the oscillator path running
  AST_OSC_RUN: assert property (@(posedge mclk) disable iff (!rstn)
    (detector_disable && !osc_disable && !divide_select) |=> oscillator_output == $past(osc_in))
    else $error("oscillator stopped by detector disable");
  // disabled detector floats its pad
  AST_FLOAT: assert property (@(posedge mclk) disable iff (!rstn)
    detector_disable |=> detector_output_oe_n) else $error("detector drove while disabled");
  // disabled detector stays idle whatever the inputs do
  AST_IGNORE: assert property (@(posedge mclk) disable iff (!rstn)
    detector_disable [*2] |-> st_r == plldet_pkg::PD_IDLE) else $error("edge acted on");
  // lone reference edge starts an up drive
  AST_UP: assert property (@(posedge mclk) disable iff (!rstn)
    (!detector_disable && st_r == plldet_pkg::PD_IDLE && ref_rise && !fb_rise) |=>
    (!detector_output_oe_n && detector_output_o)) else $error("up pulse missing");
  // up drive stands until the feedback edge
  AST_UP_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    (!detector_disable && st_r == plldet_pkg::PD_UP && !fb_rise) |=>
    (!detector_output_oe_n && detector_output_o)) else $error("up drive dropped early");
  // lone feedback edge starts a down drive
  AST_DOWN: assert property (@(posedge mclk) disable iff (!rstn)
    (!detector_disable && st_r == plldet_pkg::PD_IDLE && fb_rise && !ref_rise) |=>
    (!detector_output_oe_n && !detector_output_o)) else $error("down pulse missing");
  // down drive stands until the reference edge
  AST_DOWN_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    (!detector_disable && st_r == plldet_pkg::PD_DOWN && !ref_rise) |=>
    (!detector_output_oe_n && !detector_output_o)) else $error("down drive dropped early");
  // the trailing edge floats the pad after an up drive
  AST_END: assert property (@(posedge mclk) disable iff (!rstn)
    (st_r == plldet_pkg::PD_UP && fb_rise) |=> detector_output_oe_n)
    else $error("output not floated after both edges");
  // the trailing edge floats the pad after a down drive
  AST_DOWN_END: assert property (@(posedge mclk) disable iff (!rstn)
    (st_r == plldet_pkg::PD_DOWN && ref_rise) |=> detector_output_oe_n)
    else $error("output not floated after down drive");
  // edges in the same cycle cancel and leave the pad floating
  AST_TIE: assert property (@(posedge mclk) disable iff (!rstn)
    (!detector_disable && st_r == plldet_pkg::PD_IDLE && ref_rise && fb_rise) |=>
    detector_output_oe_n) else $error("drive on simultaneous edges");
  // no edge, no drive
  AST_IDLE_STAY: assert property (@(posedge mclk) disable iff (!rstn)
    (!detector_disable && st_r == plldet_pkg::PD_IDLE && !ref_rise && !fb_rise) |=>
    detector_output_oe_n) else $error("drive without an edge");
  // detector still compares while the oscillator is stopped
  AST_INDEP: assert property (@(posedge mclk) disable iff (!rstn)
    (!detector_disable && osc_disable && st_r == plldet_pkg::PD_IDLE && ref_rise && !fb_rise)
    |=> !detector_output_oe_n) else $error("detector stopped by oscillator disable");
endmodule : plldet_core
`default_nettype wire

// file: tb/plldet_source.sv
// Purpose: reference source and feedback counter image for the detector
// Assumes: the bench asks for each line level one cycle ahead
// Notes: lines move on the falling edge only, never on the sampling edge
`default_nettype none
module plldet_source (
  input wire logic mclk, // system clock
  input wire logic ref_req, // bench wants the reference high
  input wire logic fb_req, // bench wants the counter output high
  output logic ref_in, // reference frequency line
  output logic fb_in // feedback counter line
);
  timeunit 1ns;
  timeprecision 1ns;
  // one driver per line; unknown only until the first falling edge, in reset
  // lines follow the bench requests, random levels in the random test rather than steady clocks
  always @(negedge mclk) begin
    ref_in <= ref_req;
    fb_in <= fb_req;
  end
endmodule : plldet_source
`default_nettype wire

// file: tb/pll_phase_detector_and_divider_bench.sv
// Purpose: random and corner stimulus with a cycle model of the block
// Assumes: latency of one edge from sampled pins to outputs
// Notes: detector pins are held low before disable is released
`default_nettype none
module pll_phase_detector_and_divider_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0, rstn = 1'h0; // clock and reset
  logic [5:0] v = 6'h00; // osc, select, osc off, det off, ref req, fb req
  logic ref_in, fb_in, osc_o, det_o, det_oe_n; // pins
  logic half, posc, pr, pf, e_osc; // expected divider and edge history
  plldet_pkg::plldet_state_type st; // expected detector state
  int err_count = 0, check_count = 0, cyc = 0, seed = 87;
  logic [5:0] dir [$] = '{6'h02, 6'h02, 6'h00, 6'h02, 6'h00, 6'h01, 6'h00, 6'h00, 6'h01,
    6'h00, 6'h02, 6'h00, 6'h03, 6'h00, 6'h30, 6'h10, 6'h30, 6'h10, 6'h30, 6'h38, 6'h18,
    6'h30, 6'h20, 6'h00, 6'h02, 6'h00, 6'h06, 6'h05, 6'h04, 6'h04, 6'h00, 6'h00}; // corners
  always #5 mclk = ~mclk;
  plldet_source src (.mclk(mclk), .ref_req(v[1]), .fb_req(v[0]), .ref_in(ref_in),
    .fb_in(fb_in));
  plldet_core dut (.mclk(mclk), .rstn(rstn), .osc_in(v[5]), .divide_select(v[4]),
    .osc_disable(v[3]), .detector_disable(v[2]), .ref_in(ref_in), .fb_in(fb_in),
    .oscillator_output(osc_o), .detector_output_o(det_o), .detector_output_oe_n(det_oe_n));
  // next detector state from edges seen this cycle
  function automatic plldet_pkg::plldet_state_type next_det(
    input plldet_pkg::plldet_state_type s, input logic r, input logic f, input logic off);
    if (off) return plldet_pkg::PD_IDLE;
    if (s == plldet_pkg::PD_IDLE && r != f) return r ? plldet_pkg::PD_UP : plldet_pkg::PD_DOWN;
    if ((s == plldet_pkg::PD_UP && f) || (s == plldet_pkg::PD_DOWN && r))
      return plldet_pkg::PD_IDLE;
    return s;
  endfunction : next_det
  // expected outputs, one register stage behind the pins
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {half, posc, pr, pf, e_osc} = 5'h00;
      st = plldet_pkg::PD_IDLE;
    end else begin
      if (v[3]) {half, posc, e_osc} = 3'h0;
      else begin
        half = half ^ (v[5] & !posc);
        posc = v[5];
        e_osc = v[4] ? half : v[5];
      end
      st = next_det(st, ref_in & !pr, fb_in & !pf, v[2]);
      pr = ref_in;
      pf = fb_in;
    end
  end
  task automatic check(input string what, input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // compare settled outputs each falling edge; cycle ceiling cuts a hang
  always @(negedge mclk) begin
    cyc++;
    check("oscillator_output", osc_o, e_osc);
    check("detector_output_oe_n", det_oe_n, st == plldet_pkg::PD_IDLE);
    if (st != plldet_pkg::PD_IDLE) check("detector_output_o", det_o, st == plldet_pkg::PD_UP);
    if (cyc == 4000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'h1;
    foreach (dir[i]) begin
      @(negedge mclk);
      v <= dir[i];
    end
    $display("corner test done");
    // detector stays enabled here: disable is covered by the corners;
    // select high three cycles in four, the halved setting being the quiet one
    repeat (2000) begin
      @(negedge mclk);
      v <= (6'($random(seed)) & 6'h2b) | {1'h0, |2'($random(seed)), 4'h0};
    end
    $display("random test done");
    stop_test();
  end
endmodule : pll_phase_detector_and_divider_bench
`default_nettype wire
